//--- common/tpo_grp_if.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Carries one pattern group's settings and strobes to its slice.
// Assumes: Strobes are already registered once in the system clock domain.
// Notes:   The slice answers with a per-bit load mask.
//////////////////////////////////////////////////////////////////////////////
interface tpo_grp_if;
  logic [1:0] sel;
  logic       split_edges;
  logic [3:0] match_a;
  logic [3:0] match_b;
  logic [3:0] staged;
  logic [3:0] enable;
  logic [3:0] load;

  modport owner (output sel, output split_edges, output match_a, output match_b,
                 output staged, output enable, input load);
  modport group (input sel, input split_edges, input match_a, input match_b,
                 input staged, input enable, output load);
endinterface : tpo_grp_if

//--- common/tpo_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the timed pattern output block.
// Assumes: APB with 32-bit data, each register in one aligned word.
// Notes:   Only the low byte of each word is used; the rest reads as zero.
//////////////////////////////////////////////////////////////////////////////
package tpo_pkg;

  localparam int unsigned GROUPS    = 4;
  localparam int unsigned GRP_W     = 4;
  localparam int unsigned CHANNELS  = 4;
  localparam int unsigned PINS      = 16;
  localparam int unsigned ADDR_W    = 8;

  // Register byte addresses.
  localparam logic [7:0] OFF_LOWER_STAGED = 8'h00;
  localparam logic [7:0] OFF_UPPER_STAGED = 8'h04;
  localparam logic [7:0] OFF_LOWER_ENABLE = 8'h08;
  localparam logic [7:0] OFF_UPPER_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_TRIG_SELECT  = 8'h10;
  localparam logic [7:0] OFF_OVERLAP_MODE = 8'h14;
  localparam logic [7:0] OFF_PORT_DATA_LO = 8'h18;
  localparam logic [7:0] OFF_PORT_DATA_HI = 8'h1c;
  localparam logic [7:0] OFF_PORT_FUNC_LO = 8'h20;
  localparam logic [7:0] OFF_PORT_FUNC_HI = 8'h24;

  // Reset values.
  localparam logic [7:0] RST_STAGED       = 8'h00;
  localparam logic [7:0] RST_ENABLE       = 8'h00;
  localparam logic [7:0] RST_TRIG_SELECT  = 8'hff;
  localparam logic [7:0] RST_OVERLAP_MODE = 8'hf0;
  localparam logic [7:0] RST_PORT_DATA    = 8'h00;
  localparam logic [7:0] RST_PORT_FUNC    = 8'h00;

  // Field layout of the overlap mode register.
  localparam int unsigned OVL_SPLIT_LSB   = 0;
  localparam logic [3:0]  OVL_RESERVED    = 4'hf;

endpackage : tpo_pkg

//--- logic/tpo_group.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Decides which bits of one 4-bit pattern group load this cycle.
// Assumes: Match strobes last exactly one cycle.
// Notes:   Pure combinational; the owner applies the mask to port data.
//////////////////////////////////////////////////////////////////////////////
module tpo_group (
  tpo_grp_if.group gif
);

  logic trig_a;
  logic trig_b;

  always_comb begin
    trig_a = gif.match_a[gif.sel];
    trig_b = gif.match_b[gif.sel] & gif.split_edges;
  end

  // RULE9 RULE10 mode dependent loading
  // RULE15 split edge transfer
  always_comb begin
    if (trig_a) begin
      gif.load = gif.enable;
    end else if (trig_b) begin
      // Only falling bits move early, which opens the non-overlap gap.
      gif.load = gif.enable & ~gif.staged;
    end else begin
      gif.load = 4'h0;
    end
  end

endmodule : tpo_group

//--- logic/tpo_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Timed pattern output unit with APB registers and 16 pattern pins.
// Assumes: Timer match strobes are synchronous one-cycle pulses.
// Notes:   Register contents survive standby because only reset clears them.
//////////////////////////////////////////////////////////////////////////////
//
// Local design decisions: register access over APB and the placing of the registers.

// How it works
// RULE1 - Upper bits copy only when enabled
// RULE2 - Trigger select resets to all ones
// RULE3 - Bits 7:6 pick group three channel
// RULE4 - Bits 5:4 pick group two channel
// RULE5 - Bits 3:2 pick group one channel
// RULE6 - Bits 1:0 pick group zero channel
// RULE7 - Overlap mode resets to upper ones
// RULE8 - Mode upper nibble always reads ones
// RULE9 - Ordinary mode loads on match A only
// RULE10 - Split mode times edges with A, B
// RULE11 - Timer holds period B, gap A
// RULE12 - Pin drives when function and enable set
// RULE13 - Selected match loads staged into port data
// RULE14 - Supplier rewrites staged data before next match
// RULE15 - Match B copies only zero bits
// RULE16 - Upper enables reset to zero
// RULE17 - Staged data held from B until A
// RULE18 - Transfer happens cycle after strobe
// RULE19 - Each group follows its own trigger
module tpo_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [3:0]  match_a_in,
  input  wire logic [3:0]  match_b_in,
  output logic      [15:0] pattern_pins_out,
  output logic      [15:0] pattern_oe_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [7:0]  lower_staged_pattern;
  logic [7:0]  upper_staged_pattern;
  logic [7:0]  lower_pattern_enable;
  logic [7:0]  upper_pattern_enable;
  logic [7:0]  pattern_trigger_select;
  logic [3:0]  split_edges;
  logic [15:0] port_out_data;
  logic [15:0] port_function_ctrl;
  logic [3:0]  match_a_q;
  logic [3:0]  match_b_q;
  logic        ready_q;
  logic        take;
  logic        wr_en;
  logic [15:0] load_all;
  logic [15:0] staged_all;
  logic [15:0] enable_all;
  logic [15:0] next_port_out_data;
  logic        sw_port_lo;
  logic        sw_port_hi;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Picks the 2-bit channel field of one group from the trigger select byte.
  function automatic logic [1:0] trig_field(input logic [7:0] sel, input int unsigned grp);
    trig_field = sel[2*grp +: 2];
  endfunction : trig_field

  function automatic logic addr_known(input logic [7:0] addr);
    case (addr)
      tpo_pkg::OFF_LOWER_STAGED,
      tpo_pkg::OFF_UPPER_STAGED,
      tpo_pkg::OFF_LOWER_ENABLE,
      tpo_pkg::OFF_UPPER_ENABLE,
      tpo_pkg::OFF_TRIG_SELECT,
      tpo_pkg::OFF_OVERLAP_MODE,
      tpo_pkg::OFF_PORT_DATA_LO,
      tpo_pkg::OFF_PORT_DATA_HI,
      tpo_pkg::OFF_PORT_FUNC_LO,
      tpo_pkg::OFF_PORT_FUNC_HI: addr_known = 1'b1;
      default:                   addr_known = 1'b0;
    endcase
  endfunction : addr_known

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered.

  always_comb begin
    take  = psel_in & penable_in & ~ready_q;
    wr_en = psel_in & penable_in & ready_q & pwrite_in & addr_known(paddr_in);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= take;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pslverr_out <= 1'b0;
    end else if (take) begin
      pslverr_out <= ~addr_known(paddr_in);
    end else begin
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0;
    end else if (take && !pwrite_in) begin
      case (paddr_in)
        tpo_pkg::OFF_LOWER_STAGED: prdata_out <= {24'h0, lower_staged_pattern};
        tpo_pkg::OFF_UPPER_STAGED: prdata_out <= {24'h0, upper_staged_pattern};
        tpo_pkg::OFF_LOWER_ENABLE: prdata_out <= {24'h0, lower_pattern_enable};
        tpo_pkg::OFF_UPPER_ENABLE: prdata_out <= {24'h0, upper_pattern_enable};
        tpo_pkg::OFF_TRIG_SELECT:  prdata_out <= {24'h0, pattern_trigger_select};
        // RULE8 reserved bits read one
        tpo_pkg::OFF_OVERLAP_MODE: prdata_out <= {24'h0, tpo_pkg::OVL_RESERVED, split_edges};
        tpo_pkg::OFF_PORT_DATA_LO: prdata_out <= {24'h0, port_out_data[7:0]};
        tpo_pkg::OFF_PORT_DATA_HI: prdata_out <= {24'h0, port_out_data[15:8]};
        tpo_pkg::OFF_PORT_FUNC_LO: prdata_out <= {24'h0, port_function_ctrl[7:0]};
        tpo_pkg::OFF_PORT_FUNC_HI: prdata_out <= {24'h0, port_function_ctrl[15:8]};
        default:                   prdata_out <= 32'h0;
      endcase
    end else begin
      prdata_out <= 32'h0;
    end
  end

  always_comb begin
    pready_out = ready_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      lower_staged_pattern <= tpo_pkg::RST_STAGED;
      upper_staged_pattern <= tpo_pkg::RST_STAGED;
    end else if (wr_en && paddr_in == tpo_pkg::OFF_LOWER_STAGED) begin
      lower_staged_pattern <= pwdata_in[7:0];
    end else if (wr_en && paddr_in == tpo_pkg::OFF_UPPER_STAGED) begin
      upper_staged_pattern <= pwdata_in[7:0];
    end
  end

  // RULE16 enables clear at reset
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      lower_pattern_enable <= tpo_pkg::RST_ENABLE;
      upper_pattern_enable <= tpo_pkg::RST_ENABLE;
    end else if (wr_en && paddr_in == tpo_pkg::OFF_LOWER_ENABLE) begin
      lower_pattern_enable <= pwdata_in[7:0];
    end else if (wr_en && paddr_in == tpo_pkg::OFF_UPPER_ENABLE) begin
      upper_pattern_enable <= pwdata_in[7:0];
    end
  end

  // RULE2 trigger select reset
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pattern_trigger_select <= tpo_pkg::RST_TRIG_SELECT;
    end else if (wr_en && paddr_in == tpo_pkg::OFF_TRIG_SELECT) begin
      pattern_trigger_select <= pwdata_in[7:0];
    end
  end

  // RULE7 overlap mode reset
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      split_edges <= tpo_pkg::RST_OVERLAP_MODE[3:0];
    end else if (wr_en && paddr_in == tpo_pkg::OFF_OVERLAP_MODE) begin
      split_edges <= pwdata_in[3:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      port_function_ctrl <= {tpo_pkg::RST_PORT_FUNC, tpo_pkg::RST_PORT_FUNC};
    end else if (wr_en && paddr_in == tpo_pkg::OFF_PORT_FUNC_LO) begin
      port_function_ctrl[7:0] <= pwdata_in[7:0];
    end else if (wr_en && paddr_in == tpo_pkg::OFF_PORT_FUNC_HI) begin
      port_function_ctrl[15:8] <= pwdata_in[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Match strobes and group slices.

  // RULE18 strobe registered once
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      match_a_q <= 4'h0;
      match_b_q <= 4'h0;
    end else begin
      match_a_q <= match_a_in;
      match_b_q <= match_b_in;
    end
  end

  always_comb begin
    staged_all = {upper_staged_pattern, lower_staged_pattern};
    enable_all = {upper_pattern_enable, lower_pattern_enable};
  end

  // RULE19 independent group slices
  for (genvar g = 0; g < tpo_pkg::GROUPS; g++) begin : gen_grp
    tpo_grp_if gif ();
    // RULE3 RULE4 RULE5 RULE6 channel field decode
    assign gif.sel         = trig_field(pattern_trigger_select, g);
    assign gif.split_edges = split_edges[g];
    assign gif.match_a     = match_a_q;
    assign gif.match_b     = match_b_q;
    assign gif.staged      = staged_all[4*g +: 4];
    assign gif.enable      = enable_all[4*g +: 4];
    assign load_all[4*g +: 4] = gif.load;
    tpo_group u_grp (
      .gif (gif)
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port output data.

  always_comb begin
    sw_port_lo = wr_en && paddr_in == tpo_pkg::OFF_PORT_DATA_LO;
    sw_port_hi = wr_en && paddr_in == tpo_pkg::OFF_PORT_DATA_HI;
    next_port_out_data = port_out_data;
    if (sw_port_lo) begin
      next_port_out_data[7:0] = pwdata_in[7:0];
    end
    if (sw_port_hi) begin
      next_port_out_data[15:8] = pwdata_in[7:0];
    end
    // RULE13 staged data loads port
    // RULE1 disabled bits keep value
    // A hardware transfer wins over a software write to the same bit.
    next_port_out_data = (next_port_out_data & ~load_all) | (staged_all & load_all);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      port_out_data <= {tpo_pkg::RST_PORT_DATA, tpo_pkg::RST_PORT_DATA};
    end else begin
      port_out_data <= next_port_out_data;
    end
  end

  always_comb begin
    pattern_pins_out = port_out_data;
  end

  // RULE12 pin enable gating
  // The enable lags a register write by one cycle so the pin stays flop driven.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pattern_oe_out <= 16'h0;
    end else begin
      pattern_oe_out <= port_function_ctrl & enable_all;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic rst_done;
  always_ff @(posedge mclk_in) begin
    rst_done <= rst_n_in;
  end

  chk_trig_sel_reset: assert property ( // RULE2
    !rst_done |-> pattern_trigger_select == 8'hff)
    else $error("trigger select not all ones after reset");

  chk_mode_reset: assert property ( // RULE7
    !rst_done |-> split_edges == 4'h0 && upper_pattern_enable == 8'h00) // RULE16
    else $error("mode or enable wrong after reset");

  chk_mode_read_ones: assert property ( // RULE8
    take && !pwrite_in && paddr_in == tpo_pkg::OFF_OVERLAP_MODE
    |=> pready_out && prdata_out[7:4] == 4'hf && prdata_out[3:0] == $past(split_edges))
    else $error("overlap mode read wrong");

  chk_upper_disabled: assert property ( // RULE1
    upper_pattern_enable == 8'h00 && !sw_port_hi
    |=> port_out_data[15:8] == $past(port_out_data[15:8]))
    else $error("disabled upper bit changed");

  chk_ordinary_load: assert property ( // RULE9
    match_a_q[pattern_trigger_select[1:0]] && !split_edges[0]
    && lower_pattern_enable[3:0] == 4'hf && !sw_port_lo
    |=> port_out_data[3:0] == $past(lower_staged_pattern[3:0])) // RULE13
    else $error("ordinary group zero load missing");

  chk_strobe_latency: assert property ( // RULE18
    match_a_in[pattern_trigger_select[7:6]] && !split_edges[3]
    ##1 (upper_pattern_enable[7:4] == 4'hf && !sw_port_hi
         && $stable(upper_staged_pattern) && $stable(pattern_trigger_select) && $stable(split_edges))
    |=> port_out_data[15:12] == $past(upper_staged_pattern[7:4], 1))
    else $error("group three not loaded one cycle after strobe");

  chk_split_b_zero: assert property ( // RULE15
    split_edges[1] && match_b_q[pattern_trigger_select[3:2]]
    && !match_a_q[pattern_trigger_select[3:2]] && !sw_port_lo
    |=> port_out_data[7:4] == ($past(port_out_data[7:4])
        & ~($past(lower_pattern_enable[7:4]) & ~$past(lower_staged_pattern[7:4]))))
    else $error("match B moved a one bit");

  chk_ordinary_ignores_b: assert property ( // RULE9
    !split_edges[2] && !match_a_q[pattern_trigger_select[5:4]] && !sw_port_hi
    |=> port_out_data[11:8] == $past(port_out_data[11:8]))
    else $error("ordinary group two moved without match A");

  chk_group_isolated: assert property ( // RULE19
    !match_a_q[pattern_trigger_select[7:6]] && !match_b_q[pattern_trigger_select[7:6]]
    && !sw_port_hi |=> $stable(port_out_data[15:12]))
    else $error("group three moved on a foreign channel");

  chk_pin_gate: assert property ( // RULE12
    port_function_ctrl == 16'h0 ##1 port_function_ctrl == 16'h0 |-> pattern_oe_out == 16'h0)
    else $error("pin enabled without port function");

  chk_pin_value: assert property ( // RULE12
    load_all == 16'h0 && !sw_port_lo && !sw_port_hi |=> $stable(pattern_pins_out))
    else $error("pins moved without a transfer or write");

  cov_ordinary_load: cover property (
    match_a_q[pattern_trigger_select[1:0]] && load_all[3:0] != 4'h0);

  cov_split_b: cover property (
    split_edges[1] && match_b_q[pattern_trigger_select[3:2]] && load_all[7:4] != 4'h0);

  cov_apb_write: cover property (wr_en ##[1:4] take);

  cov_unmapped: cover property (take && !addr_known(paddr_in));

endmodule : tpo_top

//--- sim/testbench.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the pattern output unit against a model.
// Assumes: APB answers after one wait state; strobes act one cycle later.
// Notes:   Staged data only changes while the timer is stopped.
//////////////////////////////////////////////////////////////////////////////
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic            mclk_in = 1'b0;
  logic            rst_n_in = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [3:0]      match_a;
  logic [3:0]      match_b;
  logic [15:0]     pins;
  logic [15:0]     oe;
  logic [3:0]      run = 4'h0;
  logic [3:0][7:0] period = '0;
  logic [3:0][7:0] gap = '0;
  logic [3:0]      sa_q = 4'h0;
  logic [3:0]      sb_q = 4'h0;
  logic [15:0]     ref_staged, ref_en, ref_port, ref_func;
  logic [7:0]      ref_sel;
  logic [3:0]      ref_mode;
  int              miscompares = 0;
  int              check_count = 0;
  int              ch;
  localparam logic [7:0] OFFS [10] = '{tpo_pkg::OFF_LOWER_STAGED, tpo_pkg::OFF_UPPER_STAGED,
    tpo_pkg::OFF_LOWER_ENABLE, tpo_pkg::OFF_UPPER_ENABLE, tpo_pkg::OFF_TRIG_SELECT,
    tpo_pkg::OFF_OVERLAP_MODE, tpo_pkg::OFF_PORT_DATA_LO, tpo_pkg::OFF_PORT_DATA_HI,
    tpo_pkg::OFF_PORT_FUNC_LO, tpo_pkg::OFF_PORT_FUNC_HI};

  always #5 mclk_in = ~mclk_in;

  tpo_top i_dut (
    .mclk_in          (mclk_in),
    .rst_n_in         (rst_n_in),
    .psel_in          (psel),
    .penable_in       (penable),
    .pwrite_in        (pwrite),
    .paddr_in         (paddr),
    .pwdata_in        (pwdata),
    .prdata_out       (prdata),
    .pready_out       (pready),
    .pslverr_out      (pslverr),
    .match_a_in       (match_a),
    .match_b_in       (match_b),
    .pattern_pins_out (pins),
    .pattern_oe_out   (oe)
  );

  tpo_timer_model i_timer (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .run_in      (run),
    .period_in   (period),
    .gap_in      (gap),
    .match_a_out (match_a),
    .match_b_out (match_b)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Reference model: a strobe seen at one edge moves data at the next edge.
  always @(posedge mclk_in) begin
    for (int i = 0; i < 16; i++) begin
      ch = int'(ref_sel[2 * (i / 4) +: 2]);
      if (ref_en[i] && sa_q[ch]) begin
        ref_port[i] = ref_staged[i];
      end else if (ref_en[i] && ref_mode[i / 4] && sb_q[ch] && !ref_staged[i]) begin
        ref_port[i] = 1'b0;
      end
    end
    sa_q <= rst_n_in ? match_a : 4'h0;
    sb_q <= rst_n_in ? match_b : 4'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers would hang the run, so it ends here.
    if (pready !== 1'b1) begin
      miscompares++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, addr, {24'h0, d}, r, e);
    case (addr)
      tpo_pkg::OFF_LOWER_STAGED: ref_staged[7:0] = d;
      tpo_pkg::OFF_UPPER_STAGED: ref_staged[15:8] = d;
      tpo_pkg::OFF_LOWER_ENABLE: ref_en[7:0] = d;
      tpo_pkg::OFF_UPPER_ENABLE: ref_en[15:8] = d;
      tpo_pkg::OFF_TRIG_SELECT:  ref_sel = d;
      tpo_pkg::OFF_OVERLAP_MODE: ref_mode = d[3:0];
      tpo_pkg::OFF_PORT_DATA_LO: ref_port[7:0] = d;
      tpo_pkg::OFF_PORT_DATA_HI: ref_port[15:8] = d;
      tpo_pkg::OFF_PORT_FUNC_LO: ref_func[7:0] = d;
      tpo_pkg::OFF_PORT_FUNC_HI: ref_func[15:8] = d;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, addr, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, 32'h0);
  endtask : rd

  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    {ref_staged, ref_en, ref_port, ref_func} = '0;
    ref_sel = 8'hff;
    ref_mode = 4'h0;
    check({16'h0, pins}, 32'h0);
    check({16'h0, oe}, 32'h0);
    rd(tpo_pkg::OFF_TRIG_SELECT, 32'hff);
    rd(tpo_pkg::OFF_OVERLAP_MODE, 32'hf0);
    rd(tpo_pkg::OFF_UPPER_ENABLE, 32'h00);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  d;
    void'($urandom(91243));
    do_reset();
    apb(1'b0, 8'h28, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    for (int it = 0; it < 24; it++) begin
      run <= 4'h0;
      repeat (4) @(posedge mclk_in);
      // staged data is rewritten only between runs.
      // so it never changes between match B and match A.
      for (int k = 0; k < 10; k++) begin
        d = 8'($urandom);
        wr(OFFS[k], (OFFS[k] == tpo_pkg::OFF_OVERLAP_MODE) ? {4'hf, d[3:0]} : d);
      end
      rd(tpo_pkg::OFF_TRIG_SELECT, {24'h0, ref_sel});
      rd(tpo_pkg::OFF_OVERLAP_MODE, {24'h0, 4'hf, ref_mode});
      rd(tpo_pkg::OFF_UPPER_ENABLE, {24'h0, ref_en[15:8]});
      @(posedge mclk_in);
      check({16'h0, oe}, {16'h0, ref_func & ref_en});
      for (int c = 0; c < 4; c++) begin
        period[c] <= 8'(2 + $urandom % 8);
        gap[c]    <= 8'($urandom % 12);
      end
      run <= 4'($urandom);
      repeat (40) @(posedge mclk_in);
      run <= 4'h0;
      repeat (4) @(posedge mclk_in);
      check({16'h0, pins}, {16'h0, ref_port});
      rd(tpo_pkg::OFF_PORT_DATA_LO, {24'h0, ref_port[7:0]});
      rd(tpo_pkg::OFF_PORT_DATA_HI, {24'h0, ref_port[15:8]});
    end
    run <= 4'hf;
    repeat (10) @(posedge mclk_in);
    do_reset();
    run <= 4'h0;
    results();
  end
endmodule : testbench

//--- sim/tpo_timer_model.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Behavioural timer unit that makes compare match A and B strobes.
// Assumes: One clock; strobes are one-cycle pulses, channel n on bit n.
// Notes:   A stopped channel restarts its count from zero.
//////////////////////////////////////////////////////////////////////////////
module tpo_timer_model (
  input  wire logic            mclk_in,
  input  wire logic            rst_n_in,
  input  wire logic [3:0]      run_in,
  input  wire logic [3:0][7:0] period_in,
  input  wire logic [3:0][7:0] gap_in,
  output logic      [3:0]      match_a_out,
  output logic      [3:0]      match_b_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0][7:0] count;

  // period ends on B, gap ends on A.
  always_ff @(posedge mclk_in) begin
    for (int ch = 0; ch < 4; ch++) begin
      if (!rst_n_in || !run_in[ch]) begin
        count[ch]       <= 8'h00;
        match_a_out[ch] <= 1'b0;
        match_b_out[ch] <= 1'b0;
      end else begin
        match_a_out[ch] <= (count[ch] == gap_in[ch]);
        match_b_out[ch] <= (count[ch] == period_in[ch] - 8'h01);
        count[ch]       <= (count[ch] == period_in[ch] - 8'h01) ? 8'h00 : count[ch] + 8'h01;
      end
    end
  end
endmodule : tpo_timer_model
